/* sim/crystal_osc_control_tb_top.sv */
// Self-checking testbench of the crystal oscillator control block
`timescale 1ns/1ps
`default_nettype none
module crystal_osc_control_tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        xtal_tick;
  logic        wake_event;
  logic        osc_enable;
  logic        osc_run;
  logic        osc_usable;
  logic        tick_on;
  logic [1:0]  div;
  logic [31:0] exp_q[$];
  logic [11:0] code;
  logic [7:0]  n;
  logic [31:0] bad;
  int          error_cnt;
  int          n_checks;

  crystal_osc_control crystal_osc_control_inst (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pstrb      (pstrb),
    .pready     (pready),
    .prdata     (prdata),
    .pslverr    (pslverr),
    .xtal_tick  (xtal_tick),
    .wake_event (wake_event),
    .osc_enable (osc_enable),
    .osc_run    (osc_run),
    .osc_usable (osc_usable)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Crystal tick every fourth cycle while enabled
  always @(posedge pclk)
  begin
    div       <= div + 2'h1;
    xtal_tick <= tick_on && (div == 2'h3);
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // Read data monitor
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      chk("pslverr", {31'h0, pslverr}, 32'h0);
      if (exp_q.size() > 0)
        chk("prdata", prdata, exp_q.pop_front());
      else
        chk("prdata unexpected", prdata, 32'hFFFFFFFF);
    end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      chk("pready", {31'h0, pready}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
  endtask : idle

  initial
  begin
    #150000;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, wake_event, tick_on, div} = '0;
    pstrb = 4'hF;
    xtal_tick = 1'b0;
    presetn = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(97714));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(xtal_ctrl_pkg::OFF_CONTROL, 32'h00D1EAA0);
    rd(xtal_ctrl_pkg::OFF_STATUS, 32'h0);
    rd(xtal_ctrl_pkg::OFF_PAUSE, xtal_ctrl_pkg::RESUME_CODE);
    rd(xtal_ctrl_pkg::OFF_SETTLE, 32'h000000C4);
    rd(xtal_ctrl_pkg::OFF_COUNT, 32'h0);
    rd(8'h10, 32'h0);
    apb(1'b1, xtal_ctrl_pkg::OFF_SETTLE, 32'hFFFFFFFF);
    rd(xtal_ctrl_pkg::OFF_SETTLE, 32'h00103FFF);
    apb(1'b1, xtal_ctrl_pkg::OFF_SETTLE, 32'h00000001);
    tick_on <= 1'b1;
    // Enable and settle over one unit of 256 ticks
    apb(1'b1, xtal_ctrl_pkg::OFF_CONTROL, 32'h00FABAA0);
    idle(3);
    chk("osc_enable", {31'h0, osc_enable}, 32'h1);
    rd(xtal_ctrl_pkg::OFF_STATUS, 32'h00001000);
    idle(4 * 245);
    chk("osc_usable early", {31'h0, osc_usable}, 32'h0);
    idle(4 * 20);
    chk("osc_usable", {31'h0, osc_usable}, 32'h1);
    rd(xtal_ctrl_pkg::OFF_STATUS, 32'h80001000);
    apb(1'b1, xtal_ctrl_pkg::OFF_CONTROL, 32'h00D1EAA0);
    idle(3);
    chk("osc_enable off", {31'h0, osc_enable}, 32'h0);
    chk("osc_usable off", {31'h0, osc_usable}, 32'h0);
    // Quadrupled delay
    apb(1'b1, xtal_ctrl_pkg::OFF_SETTLE, 32'h00100001);
    apb(1'b1, xtal_ctrl_pkg::OFF_CONTROL, 32'h00FABAA0);
    idle(4 * 1000);
    chk("osc_usable x4 early", {31'h0, osc_usable}, 32'h0);
    idle(4 * 40);
    chk("osc_usable x4", {31'h0, osc_usable}, 32'h1);
    // Pause and wake
    apb(1'b1, xtal_ctrl_pkg::OFF_SETTLE, 32'h00000001);
    apb(1'b1, xtal_ctrl_pkg::OFF_PAUSE, xtal_ctrl_pkg::PAUSE_CODE);
    idle(3);
    chk("osc_run paused", {31'h0, osc_run}, 32'h0);
    chk("osc_usable paused", {31'h0, osc_usable}, 32'h0);
    rd(xtal_ctrl_pkg::OFF_PAUSE, xtal_ctrl_pkg::PAUSE_CODE);
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    idle(3);
    chk("osc_run woken", {31'h0, osc_run}, 32'h1);
    idle(4 * 245);
    chk("osc_usable wake early", {31'h0, osc_usable}, 32'h0);
    idle(4 * 20);
    chk("osc_usable wake", {31'h0, osc_usable}, 32'h1);
    // Illegal writes while disabled
    apb(1'b1, xtal_ctrl_pkg::OFF_CONTROL, 32'h00D1EAA0);
    bad = $urandom();
    if (bad == xtal_ctrl_pkg::PAUSE_CODE || bad == xtal_ctrl_pkg::RESUME_CODE)
      bad = 32'h0;
    apb(1'b1, xtal_ctrl_pkg::OFF_PAUSE, bad);
    rd(xtal_ctrl_pkg::OFF_PAUSE, xtal_ctrl_pkg::RESUME_CODE);
    rd(xtal_ctrl_pkg::OFF_STATUS, 32'h01000000);
    apb(1'b1, xtal_ctrl_pkg::OFF_STATUS, 32'h01000000);
    rd(xtal_ctrl_pkg::OFF_STATUS, 32'h0);
    apb(1'b1, xtal_ctrl_pkg::OFF_CONTROL, {20'h00D1E, 10'h2A8, 2'($urandom_range(3, 1))});
    rd(xtal_ctrl_pkg::OFF_CONTROL, 32'h00D1EAA0);
    rd(xtal_ctrl_pkg::OFF_STATUS, 32'h01000000);
    apb(1'b1, xtal_ctrl_pkg::OFF_STATUS, 32'h01000000);
    code = 12'($urandom());
    if (code == xtal_ctrl_pkg::ENABLE_OFF_CODE || code == xtal_ctrl_pkg::ENABLE_ON_CODE)
      code = 12'h123;
    apb(1'b1, xtal_ctrl_pkg::OFF_CONTROL, {8'h00, code, 12'hAA0});
    rd(xtal_ctrl_pkg::OFF_CONTROL, {8'h00, code, 12'hAA0});
    rd(xtal_ctrl_pkg::OFF_STATUS, 32'h01001000);
    chk("osc_enable any code", {31'h0, osc_enable}, 32'h1);
    // Down counter
    tick_on <= 1'b0;
    idle(4);
    apb(1'b1, xtal_ctrl_pkg::OFF_COUNT, 32'hFFFFFFFF);
    rd(xtal_ctrl_pkg::OFF_COUNT, 32'h000000FF);
    n = 8'($urandom_range(255, 1));
    apb(1'b1, xtal_ctrl_pkg::OFF_COUNT, {24'h0, n});
    rd(xtal_ctrl_pkg::OFF_COUNT, {24'h0, n});
    tick_on <= 1'b1;
    idle(4 * (int'(n) + 3));
    tick_on <= 1'b0;
    idle(4);
    rd(xtal_ctrl_pkg::OFF_COUNT, 32'h0);
    idle(3);
    complete_run();
  end
endmodule : crystal_osc_control_tb_top
`default_nettype wire

/* verilog/crystal_osc_control.sv */
// Register block and control logic of the crystal oscillator
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module crystal_osc_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        xtal_tick,
  input  wire logic        wake_event,
  output logic             osc_enable,
  output logic             osc_run,
  output logic             osc_usable
);
  logic [11:0] enable_code;
  logic        illegal_write_flag;
  logic        paused;
  logic [13:0] delay_units;
  logic        delay_quadruple;
  logic        usable;
  logic [7:0]  count;
  logic        enabled;
  logic        running;
  logic        wr_ctrl;
  logic        wr_pause;
  logic        wr_settle;
  logic        wr_count;
  logic        wr_status;
  logic        setup;
  logic        access;
  logic        bad_ctrl;
  logic        bad_pause;
  logic [31:0] next_prdata;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  assign setup     = psel && !penable;
  // Writes land at the edge that completes the access phase
  assign access    = psel && penable && pready;
  assign wr_ctrl   = access && pwrite && addr_hit(paddr, xtal_ctrl_pkg::OFF_CONTROL);
  assign wr_status = access && pwrite && addr_hit(paddr, xtal_ctrl_pkg::OFF_STATUS);
  assign wr_pause  = access && pwrite && addr_hit(paddr, xtal_ctrl_pkg::OFF_PAUSE);
  assign wr_settle = access && pwrite && addr_hit(paddr, xtal_ctrl_pkg::OFF_SETTLE);
  assign wr_count  = access && pwrite && addr_hit(paddr, xtal_ctrl_pkg::OFF_COUNT);

  // Any code except the off code enables
  assign enabled   = enable_code != xtal_ctrl_pkg::ENABLE_OFF_CODE;
  assign running   = enabled && !paused;
  assign bad_ctrl  = (pwdata[23:12] != xtal_ctrl_pkg::ENABLE_OFF_CODE &&
                      pwdata[23:12] != xtal_ctrl_pkg::ENABLE_ON_CODE) ||
                     pwdata[11:0] != xtal_ctrl_pkg::BAND_1_15;
  assign bad_pause = pwdata != xtal_ctrl_pkg::PAUSE_CODE && pwdata != xtal_ctrl_pkg::RESUME_CODE;

  // No wait state: answer in the first access-phase cycle of every transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_code <= xtal_ctrl_pkg::ENABLE_OFF_CODE;
    else if (wr_ctrl && pstrb[1] && pstrb[2])
      enable_code <= pwdata[23:12];
  end

  // Pause entry on pause code, any other full-word write or wake resumes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      paused <= 1'b0;
    else if (wr_pause && pstrb == 4'hF)
      paused <= (pwdata == xtal_ctrl_pkg::PAUSE_CODE);
    else if (wake_event)
      paused <= 1'b0;
  end

  // Sticky; cleared by writing one to bit 24, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      illegal_write_flag <= 1'b0;
    else if ((wr_ctrl && bad_ctrl) || (wr_pause && bad_pause))
      illegal_write_flag <= 1'b1;
    else if (wr_status && pstrb[3] && pwdata[xtal_ctrl_pkg::ILLEGAL_BIT])
      illegal_write_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      delay_units     <= xtal_ctrl_pkg::DELAY_RESET;
      delay_quadruple <= 1'b0;
    end
    else if (wr_settle)
    begin
      if (pstrb[0])
        delay_units[7:0] <= pwdata[7:0];
      if (pstrb[1])
        delay_units[13:8] <= pwdata[13:8];
      if (pstrb[2])
        delay_quadruple <= pwdata[xtal_ctrl_pkg::QUAD_BIT];
    end
  end

  xtal_settle_timer u_settle (
    .pclk        (pclk),
    .presetn     (presetn),
    .xtal_tick   (xtal_tick),
    .running     (running),
    .delay_units (delay_units),
    .quadruple   (delay_quadruple),
    .usable      (usable)
  );

  xtal_down_counter u_count (
    .pclk       (pclk),
    .presetn    (presetn),
    .xtal_tick  (xtal_tick),
    .load       (wr_count && pstrb[0] && pwdata[7:0] != 8'h00),
    .load_value (pwdata[7:0]),
    .count      (count)
  );

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb
  begin
    next_prdata = 32'h00000000;
    if (addr_hit(paddr, xtal_ctrl_pkg::OFF_CONTROL))
      next_prdata = {8'h00, enable_code, xtal_ctrl_pkg::BAND_1_15};
    else if (addr_hit(paddr, xtal_ctrl_pkg::OFF_STATUS))
    begin
      next_prdata[xtal_ctrl_pkg::USABLE_BIT]  = usable;
      next_prdata[xtal_ctrl_pkg::ILLEGAL_BIT] = illegal_write_flag;
      next_prdata[xtal_ctrl_pkg::ENABLED_BIT] = enabled;
      next_prdata[1:0]                        = 2'h0;
    end
    else if (addr_hit(paddr, xtal_ctrl_pkg::OFF_PAUSE))
      next_prdata = paused ? xtal_ctrl_pkg::PAUSE_CODE : xtal_ctrl_pkg::RESUME_CODE;
    else if (addr_hit(paddr, xtal_ctrl_pkg::OFF_SETTLE))
    begin
      next_prdata[xtal_ctrl_pkg::DELAY_MSB:0] = delay_units;
      next_prdata[xtal_ctrl_pkg::QUAD_BIT]    = delay_quadruple;
    end
    else if (addr_hit(paddr, xtal_ctrl_pkg::OFF_COUNT))
      next_prdata[7:0] = count;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
      prdata <= next_prdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_enable <= 1'b0;
      osc_run    <= 1'b0;
      osc_usable <= 1'b0;
    end
    else
    begin
      osc_enable <= enabled;
      osc_run    <= running;
      osc_usable <= usable;
    end
  end

  property p_disable_code_off;
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pstrb[2:1] == 2'h3 && pwdata[23:12] == xtal_ctrl_pkg::ENABLE_OFF_CODE) |=> !enabled ##1 !osc_enable;
  endproperty
  a_disable_code_off: assert property (p_disable_code_off) else $error("Off code did not disable");

  property p_other_code_on;
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pstrb[2:1] == 2'h3 && pwdata[23:12] != xtal_ctrl_pkg::ENABLE_OFF_CODE) |=> ##1 osc_enable;
  endproperty
  a_other_code_on: assert property (p_other_code_on) else $error("Non-off code did not enable");

  property p_usable_needs_run;
    @(posedge pclk) disable iff (!presetn)
    usable |-> $past(running);
  endproperty
  a_usable_needs_run: assert property (p_usable_needs_run) else $error("Usable without running");

  property p_bad_write_flag;
    @(posedge pclk) disable iff (!presetn)
    (wr_pause && bad_pause) |=> illegal_write_flag && !paused;
  endproperty
  a_bad_write_flag: assert property (p_bad_write_flag) else $error("Bad pause write not flagged");

  sequence s_pause_written;
    wr_pause && pstrb == 4'hF && pwdata == xtal_ctrl_pkg::PAUSE_CODE;
  endsequence
  property p_pause_stops;
    @(posedge pclk) disable iff (!presetn)
    s_pause_written |=> !running ##1 !usable ##1 !osc_usable;
  endproperty
  a_pause_stops: assert property (p_pause_stops) else $error("Pause left oscillator usable");

  property p_count_stops_zero;
    @(posedge pclk) disable iff (!presetn)
    (count == 8'h00 && !wr_count) |=> count == 8'h00;
  endproperty
  a_count_stops_zero: assert property (p_count_stops_zero) else $error("Counter left zero");

  property p_count_load;
    @(posedge pclk) disable iff (!presetn)
    (wr_count && pstrb[0] && pwdata[7:0] != 8'h00) |=> count == $past(pwdata[7:0]);
  endproperty
  a_count_load: assert property (p_count_load) else $error("Counter did not load");

  property p_wake_resettles;
    @(posedge pclk) disable iff (!presetn)
    (paused && wake_event && enabled && !wr_pause && delay_units != 14'h0000) |=> !usable [*2];
  endproperty
  a_wake_resettles: assert property (p_wake_resettles) else $error("Usable right after wake");

  sequence s_status_read;
    setup && !pwrite && addr_hit(paddr, xtal_ctrl_pkg::OFF_STATUS);
  endsequence
  property p_status_usable;
    @(posedge pclk) disable iff (!presetn)
    s_status_read |=> prdata[xtal_ctrl_pkg::USABLE_BIT] == $past(usable);
  endproperty
  a_status_usable: assert property (p_status_usable) else $error("Status usable bit wrong");

  property p_status_enabled;
    @(posedge pclk) disable iff (!presetn)
    s_status_read |=> prdata[xtal_ctrl_pkg::ENABLED_BIT] == $past(enabled);
  endproperty
  a_status_enabled: assert property (p_status_enabled) else $error("Status enabled bit wrong");

  property p_band_fixed;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && addr_hit(paddr, xtal_ctrl_pkg::OFF_CONTROL)) |=> prdata[11:0] == xtal_ctrl_pkg::BAND_1_15;
  endproperty
  a_band_fixed: assert property (p_band_fixed) else $error("Band field not fixed");

  property p_bad_ctrl_flag;
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && bad_ctrl) |=> illegal_write_flag;
  endproperty
  a_bad_ctrl_flag: assert property (p_bad_ctrl_flag) else $error("Bad control write not flagged");

  property p_other_pause_resumes;
    @(posedge pclk) disable iff (!presetn)
    (wr_pause && pstrb == 4'hF && pwdata != xtal_ctrl_pkg::PAUSE_CODE) |=> !paused;
  endproperty
  a_other_pause_resumes: assert property (p_other_pause_resumes) else $error("Pause kept after other write");

  property p_stopped_not_usable;
    @(posedge pclk) disable iff (!presetn)
    !running |=> !usable;
  endproperty
  a_stopped_not_usable: assert property (p_stopped_not_usable) else $error("Usable while stopped");

  property p_count_steps;
    @(posedge pclk) disable iff (!presetn)
    (xtal_tick && count != 8'h00 && !wr_count) |=> count == $past(count) - 8'h01;
  endproperty
  a_count_steps: assert property (p_count_steps) else $error("Counter did not step down");
endmodule : crystal_osc_control
`default_nettype wire

/* verilog/xtal_ctrl_pkg.sv */
// Package of offsets, fields, codes and reset values for the crystal oscillator control
package xtal_ctrl_pkg;
  localparam logic [7:0]  OFF_CONTROL      = 8'h00;
  localparam logic [7:0]  OFF_STATUS       = 8'h04;
  localparam logic [7:0]  OFF_PAUSE        = 8'h08;
  localparam logic [7:0]  OFF_SETTLE       = 8'h0C;
  localparam logic [7:0]  OFF_COUNT        = 8'h1C;
  localparam int          ENABLE_MSB       = 23;
  localparam int          ENABLE_LSB       = 12;
  localparam int          BAND_MSB         = 11;
  localparam int          BAND_LSB         = 0;
  localparam int          USABLE_BIT       = 31;
  localparam int          ILLEGAL_BIT      = 24;
  localparam int          ENABLED_BIT      = 12;
  localparam int          QUAD_BIT         = 20;
  localparam int          DELAY_MSB        = 13;
  localparam int          DELAY_WIDTH      = 14;
  localparam int          COUNT_WIDTH      = 8;
  localparam int          UNIT_SHIFT       = 8;
  localparam int          QUAD_SHIFT       = 2;
  localparam logic [11:0] ENABLE_OFF_CODE  = 12'hD1E;
  localparam logic [11:0] ENABLE_ON_CODE   = 12'hFAB;
  localparam logic [11:0] BAND_1_15        = 12'hAA0;
  localparam logic [31:0] PAUSE_CODE       = 32'h636F6D61;
  localparam logic [31:0] RESUME_CODE      = 32'h77616B65;
  localparam logic [13:0] DELAY_RESET      = 14'h00C4;
  localparam int          SETTLE_CNT_WIDTH = 24;
endpackage : xtal_ctrl_pkg

/* verilog/xtal_down_counter.sv */
// Eight-bit down counter stepped by the crystal
`timescale 1ns/1ps
`default_nettype none
module xtal_down_counter #(
  parameter int WIDTH = xtal_ctrl_pkg::COUNT_WIDTH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             xtal_tick,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic      [WIDTH-1:0] count
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (xtal_tick && count != '0)
      count <= count - WIDTH'(1);
  end
endmodule : xtal_down_counter
`default_nettype wire

/* verilog/xtal_settle_timer.sv */
// Settle timer counting crystal cycles after start or wake
`timescale 1ns/1ps
`default_nettype none
module xtal_settle_timer #(
  parameter int WIDTH = xtal_ctrl_pkg::SETTLE_CNT_WIDTH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             xtal_tick,
  input  wire logic             running,
  input  wire logic [13:0]      delay_units,
  input  wire logic             quadruple,
  output logic                  usable
);
  logic [WIDTH-1:0] elapsed;
  logic [WIDTH-1:0] target;

  // Units of 256 periods, times four when asked
  always_comb
  begin
    target = WIDTH'({delay_units, 8'h00});
    if (quadruple)
      target = WIDTH'({delay_units, 10'h000});
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      elapsed <= '0;
      usable  <= 1'b0;
    end
    else if (!running)
    begin
      elapsed <= '0;
      usable  <= 1'b0;
    end
    else if (!usable)
    begin
      if (elapsed >= target)
        usable <= 1'b1;
      else if (xtal_tick)
        elapsed <= elapsed + WIDTH'(1);
    end
  end
endmodule : xtal_settle_timer
`default_nettype wire
